// ==== rtl/dcsc_regs.svh ====
// Register offsets, field positions and option codes for the clock source control.
// Assumes inclusion by bare name from the package and the design module.
`ifndef DCSC_REGS_SVH
`define DCSC_REGS_SVH
`define DCSC_ADR_CTRL 8'h00
`define DCSC_ADR_CMD 8'h04
`define DCSC_ADR_STATUS 8'h08
`define DCSC_CTRL_BOOST 0
`define DCSC_CTRL_FAST 1
`define DCSC_CMD_FAST 0
`define DCSC_CMD_SLOW 1
`define DCSC_CMD_HALT 2
`define DCSC_CMD_STOP 3
`define DCSC_ST_FAST 0
`define DCSC_ST_HALT 1
`define DCSC_ST_STOP 2
`define DCSC_ST_SWITCH 3
`define DCSC_ST_SLOW_EN 4
`define DCSC_ST_FAST_EN 5
`define DCSC_ST_GATE 6
`define DCSC_MODE_FAST 2'b01
`define DCSC_MODE_SLOW 2'b10
`define DCSC_MODE_DUAL 2'b11
`define DCSC_SLOW_XTAL 1'b1
`define DCSC_FAST_500K 1'b1
`define DCSC_ZERO32 32'h0000_0000
`endif

// ==== rtl/dcsc_pkg.sv ====
// Types shared by the clock source control and its surroundings.
// Assumes the register header is on the include path.
`include "dcsc_regs.svh"
package dcsc_pkg;
  // Switch sequencer states, one-hot.
  typedef enum logic [2:0] {
    DCSC_RUN = 3'b001,
    DCSC_DRAIN = 3'b010,
    DCSC_ARM = 3'b100
  } dcsc_state_t;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dcsc_wb_req_t;
endpackage

// ==== rtl/dcsc_clock_ctrl.sv ====
// Clock source selection, gating and oscillator control for a small controller.
// Assumes oscillator levels arrive asynchronously and wake_i comes from clk_i logic.
`timescale 1ns/10ps
`default_nettype none
`include "dcsc_regs.svh"
module dcsc_clock_ctrl #(
  parameter logic [1:0] CLK_MODE = `DCSC_MODE_DUAL,
  parameter logic SLOW_SRC = `DCSC_SLOW_XTAL,
  parameter logic FAST_FREQ = `DCSC_FAST_500K
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire dcsc_pkg::dcsc_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator pins and sources.
  input wire logic osc_input_pin_i,
  output logic osc_output_pin_o,
  input wire logic fast_osc_i,
  // Oscillator controls.
  output logic slow_osc_en_o,
  output logic fast_osc_en_o,
  output logic drive_boost_o,
  output logic slow_is_xtal_o,
  output logic fast_500k_o,
  // Wake from halt or stop, one-cycle pulse.
  input wire logic wake_i,
  // Gated system base clock level.
  output logic base_clk_o
);
  import dcsc_pkg::*;

  // Refuse option codes that the selection logic has no path for.
  generate
    if (CLK_MODE != `DCSC_MODE_FAST && CLK_MODE != `DCSC_MODE_SLOW &&
        CLK_MODE != `DCSC_MODE_DUAL) begin : g_bad_mode
      $error("CLK_MODE must be fast-only, slow-only or dual");
    end
  endgenerate

  localparam logic HAS_FAST = CLK_MODE[0];
  localparam logic HAS_SLOW = CLK_MODE[1];

  logic ack_q;
  logic acc;
  logic wr;
  logic boost_q;
  logic want_fast_q;
  logic halt_q;
  logic stop_q;
  logic slow_s1_q, slow_s2_q, fast_s1_q, fast_s2_q;
  logic slow_lvl, fast_lvl, cur_lvl, tgt_fast, tgt_lvl, need_off;
  logic cur_fast_q;
  logic gate_q;
  logic base_q;
  logic osc_drv_q;
  dcsc_state_t state_q;

  // A write lands only on the edge where the master sees ack, as classic cycles require.
  assign acc = wb_req_i.cyc & wb_req_i.stb;
  assign wr = acc & wb_req_i.we & ack_q;

  // Ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // Control register: boost flag and requested source.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_q <= 1'b0;
      want_fast_q <= HAS_FAST;
    end else if (wr && wb_req_i.adr == `DCSC_ADR_CTRL && wb_req_i.sel[0]) begin
      boost_q <= wb_req_i.dat[`DCSC_CTRL_BOOST];
      want_fast_q <= wb_req_i.dat[`DCSC_CTRL_FAST] & HAS_FAST;
    end else if (wr && wb_req_i.adr == `DCSC_ADR_CMD && wb_req_i.sel[0]) begin
      if (wb_req_i.dat[`DCSC_CMD_FAST] && HAS_FAST) begin
        want_fast_q <= 1'b1;
      end else if (wb_req_i.dat[`DCSC_CMD_SLOW] && HAS_SLOW) begin
        want_fast_q <= 1'b0;
      end
    end
  end

  // Halt and stop states; a command in the same cycle as a wake wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (wr && wb_req_i.adr == `DCSC_ADR_CMD && wb_req_i.sel[0] &&
                 (wb_req_i.dat[`DCSC_CMD_HALT] || wb_req_i.dat[`DCSC_CMD_STOP])) begin
      halt_q <= wb_req_i.dat[`DCSC_CMD_HALT] & ~wb_req_i.dat[`DCSC_CMD_STOP];
      stop_q <= wb_req_i.dat[`DCSC_CMD_STOP];
    end else if (wake_i) begin
      halt_q <= 1'b0;
      stop_q <= 1'b0;
    end
  end

  // Register read data; unmapped addresses read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `DCSC_ZERO32;
    end else begin
      wb_dat_o <= `DCSC_ZERO32;
      if (acc && !ack_q) begin
        case (wb_req_i.adr)
          `DCSC_ADR_CTRL: begin
            wb_dat_o[`DCSC_CTRL_BOOST] <= boost_q;
            wb_dat_o[`DCSC_CTRL_FAST] <= want_fast_q;
          end
          `DCSC_ADR_STATUS: begin
            wb_dat_o[`DCSC_ST_FAST] <= cur_fast_q;
            wb_dat_o[`DCSC_ST_HALT] <= halt_q;
            wb_dat_o[`DCSC_ST_STOP] <= stop_q;
            wb_dat_o[`DCSC_ST_SWITCH] <= (state_q != DCSC_RUN);
            wb_dat_o[`DCSC_ST_SLOW_EN] <= slow_osc_en_o;
            wb_dat_o[`DCSC_ST_FAST_EN] <= fast_osc_en_o;
            wb_dat_o[`DCSC_ST_GATE] <= gate_q;
          end
          default: begin
            wb_dat_o <= `DCSC_ZERO32;
          end
        endcase
      end
    end
  end

  // Oscillator enables follow the build option and the stop state.
  assign slow_osc_en_o = HAS_SLOW & ~stop_q;
  assign fast_osc_en_o = HAS_FAST & ~stop_q;
  assign drive_boost_o = boost_q & SLOW_SRC;
  assign slow_is_xtal_o = SLOW_SRC;
  assign fast_500k_o = FAST_FREQ;

  // Two-flop synchronisers for the free-running oscillator levels.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
    end else begin
      slow_s1_q <= osc_input_pin_i;
      slow_s2_q <= slow_s1_q;
      fast_s1_q <= fast_osc_i;
      fast_s2_q <= fast_s1_q;
    end
  end

  // Inverting crystal amplifier output; held low when the oscillator is off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_drv_q <= 1'b0;
    end else begin
      osc_drv_q <= slow_osc_en_o & ~slow_s2_q;
    end
  end
  assign osc_output_pin_o = osc_drv_q;

  // Levels are used unmasked, so a stop lets the running phase end on its own edge.
  assign slow_lvl = slow_s2_q;
  assign fast_lvl = fast_s2_q;
  assign cur_lvl = cur_fast_q ? fast_lvl : slow_lvl;
  // Halt forces slow in dual builds; single-source builds have one choice.
  assign tgt_fast = HAS_FAST & (~HAS_SLOW | (want_fast_q & ~halt_q));
  assign tgt_lvl = tgt_fast ? fast_lvl : slow_lvl;
  assign need_off = stop_q | (tgt_fast != cur_fast_q);

  // Switch sequencer: the gate only opens or closes while the source is low,
  // so no phase is cut short, at the price of up to one source period of idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DCSC_RUN;
      cur_fast_q <= HAS_FAST & ~HAS_SLOW;
      gate_q <= 1'b0;
    end else begin
      case (state_q)
        DCSC_RUN: begin
          if (!gate_q && !cur_lvl && !stop_q) begin
            gate_q <= 1'b1;
          end else if (need_off && gate_q && !cur_lvl) begin
            gate_q <= 1'b0;
            state_q <= DCSC_DRAIN;
          end
        end
        DCSC_DRAIN: begin
          cur_fast_q <= tgt_fast;
          state_q <= DCSC_ARM;
        end
        DCSC_ARM: begin
          if (tgt_fast != cur_fast_q) begin
            state_q <= DCSC_DRAIN;
          end else if (!stop_q && !cur_lvl) begin
            gate_q <= 1'b1;
            state_q <= DCSC_RUN;
          end
        end
        default: begin
          state_q <= DCSC_RUN;
          gate_q <= 1'b0;
        end
      endcase
    end
  end

  // Registered base clock level from the gated source.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_q <= 1'b0;
    end else begin
      base_q <= gate_q & cur_lvl;
    end
  end
  assign base_clk_o = base_q;

  // Bus answer sequence.
  sequence s_req;
    acc && !ack_q;
  endsequence
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");

  property p_boost;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_req_i.adr == `DCSC_ADR_CTRL && wb_req_i.sel[0])
      |=> (drive_boost_o == ($past(wb_req_i.dat[`DCSC_CTRL_BOOST]) & SLOW_SRC));
  endproperty
  a_boost: assert property (p_boost) else $error("boost flag not taken");

  property p_stop_osc;
    @(posedge clk_i) disable iff (rst_i) stop_q |-> !slow_osc_en_o && !fast_osc_en_o;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator runs in stop");

  property p_stop_cmd;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_req_i.adr == `DCSC_ADR_CMD && wb_req_i.sel[0] &&
       wb_req_i.dat[`DCSC_CMD_STOP]) |=> !fast_osc_en_o;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("fast osc not off after stop");

  property p_fast_only;
    @(posedge clk_i) disable iff (rst_i) !HAS_SLOW |-> !slow_osc_en_o && cur_fast_q;
  endproperty
  a_fast_only: assert property (p_fast_only) else $error("slow osc on in fast build");

  property p_slow_only;
    @(posedge clk_i) disable iff (rst_i) !HAS_FAST |-> !cur_fast_q && !fast_osc_en_o;
  endproperty
  a_slow_only: assert property (p_slow_only) else $error("fast source in slow build");

  property p_sel_gated;
    @(posedge clk_i) disable iff (rst_i) $changed(cur_fast_q) |-> !$past(gate_q, 1);
  endproperty
  a_sel_gated: assert property (p_sel_gated) else $error("source changed while gated on");

  property p_gate_low;
    @(posedge clk_i) disable iff (rst_i) $changed(gate_q) |-> !$past(cur_lvl);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate moved while clock high");

  property p_halt;
    @(posedge clk_i) disable iff (rst_i) (halt_q && HAS_SLOW) |-> !tgt_fast && slow_osc_en_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not select slow clock");

  property p_cmd_sel;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_req_i.adr == `DCSC_ADR_CMD && wb_req_i.sel[0] && HAS_FAST &&
       wb_req_i.dat[`DCSC_CMD_FAST]) |=> want_fast_q;
  endproperty
  a_cmd_sel: assert property (p_cmd_sel) else $error("fast command not taken");
endmodule
`default_nettype wire

// ==== testbench/dcsc_osc_model.sv ====
// Behavioural slow and fast oscillators that sit outside the clock controller.
// Assumes a 125 MHz bench clock; real periods are scaled down to keep runs short.
`timescale 1ns/10ps
`default_nettype none
module dcsc_osc_model #(
  parameter int SLOW_HALF_NS = 96,
  parameter int FAST_HALF_NS = 32
) (
  // Enables from the controller, bit 0 slow and bit 1 fast.
  input wire logic [1:0] en_i,
  // Oscillator levels.
  output logic [1:0] lvl_o
);
  for (genvar j = 0; j < 2; j++) begin : g_osc
    localparam int HALF = j ? FAST_HALF_NS : SLOW_HALF_NS;
    // A stopped source reads low; a restart is offset so no edge meets the clock edge.
    initial begin
      lvl_o[j] = 1'b0;
      forever begin
        if (en_i[j] === 1'b1) begin
          #(HALF) lvl_o[j] = (en_i[j] === 1'b1) ? ~lvl_o[j] : 1'b0;
        end else begin
          lvl_o[j] = 1'b0;
          @(posedge en_i[j]);
          #2;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/dcsc_clock_ctrl_tb_top.sv ====
// Self-checking bench for the clock controller in dual, fast-only and slow-only builds.
// Assumes all three builds share one bus request and answer it in step.
`timescale 1ns/10ps
`default_nettype none
`include "dcsc_regs.svh"
module dcsc_clock_ctrl_tb_top;
  import dcsc_pkg::*;
  localparam logic [1:0] MODES [3] = '{`DCSC_MODE_DUAL, `DCSC_MODE_FAST, `DCSC_MODE_SLOW};
  localparam logic [2:0] XTAL = 3'h3;
  localparam logic [2:0] F500 = 3'h5;
  localparam logic [2:0] SLOW_ON = 3'h5;
  localparam logic [2:0] FAST_ON = 3'h3;
  localparam int RUN0 [3] = '{4, 4, 12};
  logic clk_i;
  logic rst_i;
  logic wake;
  dcsc_wb_req_t req;
  wire [2:0] ack, slow_en, fast_en, boost, xtal, f500, base, osc_in, fast_in, osc_out;
  wire [31:0] rdat [3];
  logic [31:0] rd [3];
  int error_cnt, comparisons, seed, n, v, m_boost;
  int run [3];
  bit seen [3];
  bit prev [3];

  for (genvar k = 0; k < 3; k++) begin : g_dut
    dcsc_clock_ctrl #(.CLK_MODE(MODES[k]), .SLOW_SRC(XTAL[k]), .FAST_FREQ(F500[k]))
      i_dcsc_clock_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat[k]),
      .wb_ack_o(ack[k]), .osc_input_pin_i(osc_in[k]), .osc_output_pin_o(osc_out[k]),
      .fast_osc_i(fast_in[k]), .slow_osc_en_o(slow_en[k]), .fast_osc_en_o(fast_en[k]),
      .drive_boost_o(boost[k]), .slow_is_xtal_o(xtal[k]), .fast_500k_o(f500[k]),
      .wake_i(wake), .base_clk_o(base[k]));
    dcsc_osc_model i_dcsc_osc_model (.en_i({fast_en[k], slow_en[k]}),
      .lvl_o({fast_in[k], osc_in[k]}));
  end

  // Free-running system clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; the edge that samples ack is the one that completes it.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack[0] !== 1'h1 && t < 20);
    if (ack[0] !== 1'h1) begin
      error_cnt++;
      $display("mismatch wb_ack expected 1 seen %b", ack[0]);
    end
    for (int k = 0; k < 3; k++) begin
      rd[k] = rdat[k];
    end
    req <= '0;
    #1;
  endtask

  task automatic cmd(input int b);
    wb(1'h1, `DCSC_ADR_CMD, 32'h0000_0001 << b);
  endtask

  // Polls status until the switch is over, bounded since latency follows the sources.
  task automatic settle(input logic src);
    int t;
    t = 0;
    do begin
      wb(1'h0, `DCSC_ADR_STATUS, `DCSC_ZERO32);
      t++;
    end while ((rd[0][3] !== 1'h0 || rd[0][0] !== src) && t < 60);
    chk("switching", 1'h0, rd[0][3]);
    chk("source", src, rd[0][0]);
  endtask

  // Length of one whole high phase of the gated clock, in system cycles.
  task automatic run_chk(input int k, input int e);
    int t;
    t = 0;
    n = 0;
    for (int p = 0; p < 2; p++) begin
      while (base[k] !== p[0] && t < 300) begin
        @(posedge clk_i);
        t++;
      end
    end
    while (base[k] === 1'h1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    comparisons++;
    if (n < e - 1 || n > e + 1) begin
      error_cnt++;
      $display("mismatch base_clk_high_run expected %0d seen %0d", e, n);
    end
  endtask

  task automatic wake_up();
    @(posedge clk_i);
    wake <= 1'h1;
    @(posedge clk_i);
    wake <= 1'h0;
  endtask

  // A shortened phase anywhere after the first edge means a glitch at a switch.
  always @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (rst_i) begin
        run[k] <= 0;
        seen[k] <= 1'b0;
      end else if (base[k] !== prev[k]) begin
        if (seen[k] && run[k] < 3) begin
          error_cnt++;
          $display("mismatch base_clk_phase expected 3 seen %0d", run[k]);
        end
        seen[k] <= 1'b1;
        run[k] <= 1;
      end else begin
        run[k] <= run[k] + 1;
      end
      prev[k] <= base[k];
    end
  end

  // Watchdog against a hang.
  initial begin
    #100_000;
    error_cnt++;
    report_and_stop();
  end

  // Main sequence; the model state is the expected build table and random boost values.
  initial begin
    rst_i = 1'h1;
    wake = 1'h0;
    req = '0;
    seed = 32'h0000_be13;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    #1;
    for (int k = 0; k < 3; k++) begin
      chk("slow_is_xtal", XTAL[k], xtal[k]);
      chk("fast_500k", F500[k], f500[k]);
      chk("slow_en", SLOW_ON[k], slow_en[k]);
      chk("fast_en", FAST_ON[k], fast_en[k]);
      run_chk(k, RUN0[k]);
    end
    repeat (4) begin
      v = $random(seed);
      wb(1'h1, `DCSC_ADR_CTRL, {30'h0000_0000, 1'h1, v[0]});
      chk("boost", v[0], boost[0]);
      chk("boost_rc", 1'h0, boost[2]);
      m_boost = v[0];
      wb(1'h0, `DCSC_ADR_CTRL, `DCSC_ZERO32);
      chk("ctrl_dual", {30'h0000_0000, 1'h1, m_boost[0]}, rd[0]);
      chk("ctrl_fast", {30'h0000_0000, 1'h1, m_boost[0]}, rd[1]);
      chk("ctrl_slow", {30'h0000_0000, 1'h0, m_boost[0]}, rd[2]);
    end
    wb(1'h1, 8'h0C, 32'hffff_ffff);
    wb(1'h0, 8'h0C, `DCSC_ZERO32);
    chk("unmapped", `DCSC_ZERO32, rd[0]);
    cmd(`DCSC_CMD_SLOW);
    settle(1'h0);
    run_chk(0, 12);
    run_chk(1, 4);
    cmd(`DCSC_CMD_FAST);
    settle(1'h1);
    run_chk(0, 4);
    cmd(`DCSC_CMD_HALT);
    settle(1'h0);
    chk("halted", 1'h1, rd[0][1]);
    chk("slow_en_halt", 1'h1, slow_en[0]);
    run_chk(0, 12);
    wake_up();
    settle(1'h1);
    run_chk(0, 4);
    cmd(`DCSC_CMD_STOP);
    @(posedge clk_i);
    #1;
    chk("slow_en_stop", 3'h0, slow_en);
    chk("fast_en_stop", 3'h0, fast_en);
    chk("osc_out_stop", 3'h0, osc_out);
    wb(1'h0, `DCSC_ADR_STATUS, `DCSC_ZERO32);
    chk("stopped", 1'h1, rd[0][2]);
    chk("osc_en_status", 2'h0, rd[0][5:4]);
    repeat (40) @(posedge clk_i);
    chk("base_stop", 3'h0, base);
    wake_up();
    @(posedge clk_i);
    #1;
    chk("slow_en_wake", SLOW_ON, slow_en);
    chk("fast_en_wake", FAST_ON, fast_en);
    report_and_stop();
  end
endmodule
`default_nettype wire
